//--- shm_pkg.sv
package shm_pkg;
   // link timing
   localparam int CLK_HZ = 200_000_000;
   localparam int BAUD = 9600;
   localparam int BIT_TICKS = 16;
   localparam int TICK_DIV = CLK_HZ / (BAUD * BIT_TICKS);
   localparam int TICK_W = 11;
   localparam int FIRST_SAMPLE_TICKS = 24;
   localparam int SYNC_SLACK_TICKS = 2;
   localparam int FIRST_SAMPLE_AT = FIRST_SAMPLE_TICKS - SYNC_SLACK_TICKS;
   localparam int BIT_MID = 8;
   localparam int DATA_BITS = 8;
   localparam int FRAME_BITS = 10;
   localparam int BACKOFF_PACKETS = 3;
   localparam int BACKOFF_TICKS = BACKOFF_PACKETS * FRAME_BITS * BIT_TICKS;
   // message timing
   localparam int RESP_MIN_US = 0;
   localparam int RESP_MAX_US = 3125;
   localparam int CMD_TIMEOUT_US = 5000;
   localparam int CYCLES_PER_US = CLK_HZ / 1_000_000;
   localparam int RESP_MAX_CYCLES = RESP_MAX_US * CYCLES_PER_US;
   localparam int CMD_TIMEOUT_CYCLES = CMD_TIMEOUT_US * CYCLES_PER_US;
   localparam int TIMER_W = 21;
   // command byte layout
   localparam int CMD_FLAG_BIT = 7;
   localparam int CMD_RSV_HI = 6;
   localparam int CMD_RSV_LO = 5;
   localparam int ACK_BIT = 6;
   localparam int CODE_W = 5;
   // command sets, one bit per code
   localparam logic [31:0] CMDS_SUPPORTED = 32'h0000_00FF;
   localparam logic [31:0] CMDS_TWO_BYTE = 32'h0000_0015;
   localparam logic [31:0] CMDS_READ = 32'h0000_00EA;
   localparam logic [4:0] STATUS_CODE = 5'h05;
   // command queue towards the user
   localparam int FIFO_DEPTH = 16;
   localparam int CMD_WORD_W = CODE_W + DATA_BITS;

   function automatic logic cmd_form_ok(input logic [7:0] b);
      return b[CMD_FLAG_BIT] && (b[CMD_RSV_HI:CMD_RSV_LO] == 2'h0);
   endfunction

   function automatic logic [7:0] reply_byte(input logic [7:0] cmd, input logic ack);
      logic [7:0] r;
      r = cmd;
      r[CMD_FLAG_BIT] = 1'b0;
      r[ACK_BIT] = ack;
      return r;
   endfunction

   function automatic logic code_in(input logic [31:0] set, input logic [4:0] code);
      return set[code];
   endfunction
endpackage

//--- shm_if.sv
`timescale 1ns/10ps
interface shm_if;
   logic dev_oe;
   logic dev_out;
   logic host_oe;
   logic host_out;
   logic line;
   // open-drain wire with pull-up: low whenever an enabled driver drives low
   assign line = ~((dev_oe & ~dev_out) | (host_oe & ~host_out));
   modport dev (input line, output dev_oe, output dev_out);
   modport host (input line, output host_oe, output host_out);
endinterface

//--- shm_device.sv
`timescale 1ns/10ps

// generic queue; a full queue holds the device sequencer in S_PUSH until RESP_CYCLES runs out, then the command is refused
module shm_fifo #(parameter int WIDTH = 8, parameter int DEPTH = 16) (
   input wire logic clk_sys, // system clock
   input wire logic rst_n, // async reset, active low
   input wire logic in_valid, // write request
   output logic in_ready, // room available
   input wire logic [WIDTH-1:0] in_data, // write word
   output logic out_valid, // word available
   input wire logic out_ready, // read accept
   output logic [WIDTH-1:0] out_data // head word
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_reg, rd_reg;
   logic [AW:0] count_reg, count_next;
   logic push, pop;

   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   assign out_data = mem[rd_reg];
   assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);

   // storage carries no reset; only the pointers define state
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wr_reg] <= in_data;
      end
   end

   // pointers and registered flags
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wr_reg <= '0;
         rd_reg <= '0;
         count_reg <= '0;
         in_ready <= 1'b1;
         out_valid <= 1'b0;
      end else begin
         if (push) wr_reg <= wr_reg + 1'b1;
         if (pop) rd_reg <= rd_reg + 1'b1;
         count_reg <= count_next;
         in_ready <= count_next != (AW+1)'(DEPTH);
         out_valid <= count_next != '0;
      end
   end
endmodule

// byte receiver, fed by an already synchronised line
module shm_rx import shm_pkg::*; (
   input wire logic clk_sys, // system clock
   input wire logic rst_n, // async reset, active low
   input wire logic tick, // oversampling tick
   input wire logic line_sync, // synchronised line level
   input wire logic enable, // allow new frames
   output logic busy, // frame in progress
   output logic byte_valid, // good byte pulse
   output logic [7:0] byte_data, // received byte
   output logic frame_err // bad stop bit pulse
);
   logic prev_reg;
   logic [4:0] cnt_reg;
   logic [3:0] bit_reg;

   // line level one tick ago, for edge detection
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) prev_reg <= 1'b1;
      else if (tick) prev_reg <= line_sync;
   end

   // sampling sequence
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         busy <= 1'b0;
         cnt_reg <= '0;
         bit_reg <= '0;
         byte_data <= '0;
         byte_valid <= 1'b0;
         frame_err <= 1'b0;
      end else begin
         byte_valid <= 1'b0;
         frame_err <= 1'b0;
         if (!busy) begin
            if (tick && enable && prev_reg && !line_sync) begin
               busy <= 1'b1;
               cnt_reg <= 5'(FIRST_SAMPLE_AT - 1);
               bit_reg <= '0;
            end
         end else if (tick) begin
            if (cnt_reg != '0) begin
               cnt_reg <= cnt_reg - 1'b1;
            end else begin
               cnt_reg <= 5'(BIT_TICKS - 1);
               if (bit_reg == 4'(DATA_BITS)) begin
                  busy <= 1'b0;
                  byte_valid <= line_sync;
                  frame_err <= !line_sync;
               end else begin
                  byte_data <= {line_sync, byte_data[7:1]};
                  bit_reg <= bit_reg + 1'b1;
               end
            end
         end
      end
   end
endmodule

// byte transmitter with mid-bit contention check
module shm_tx import shm_pkg::*; (
   input wire logic clk_sys, // system clock
   input wire logic rst_n, // async reset, active low
   input wire logic tick, // oversampling tick
   input wire logic start, // send request, idle only
   input wire logic [7:0] data, // byte to send
   input wire logic line_sync, // synchronised line level
   output logic busy, // frame in progress
   output logic done, // frame sent pulse
   output logic drive_low, // pull line low
   output logic collide // contention pulse
);
   logic [9:0] frame_reg;
   logic [3:0] bits_reg;
   logic [3:0] cnt_reg;

   // the first bit may be up to one tick short as start is not tick-aligned
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         frame_reg <= '1;
         bits_reg <= '0;
         cnt_reg <= '0;
         busy <= 1'b0;
         done <= 1'b0;
         drive_low <= 1'b0;
         collide <= 1'b0;
      end else begin
         done <= 1'b0;
         collide <= 1'b0;
         if (!busy) begin
            if (start) begin
               frame_reg <= {1'b1, data, 1'b0};
               bits_reg <= 4'(FRAME_BITS - 1);
               cnt_reg <= 4'(BIT_TICKS - 1);
               busy <= 1'b1;
               drive_low <= 1'b1;
            end
         end else if (tick) begin
            if (cnt_reg == 4'(BIT_MID) && frame_reg[0] && !line_sync) begin
               collide <= 1'b1;
               busy <= 1'b0;
               drive_low <= 1'b0;
            end else if (cnt_reg != '0) begin
               cnt_reg <= cnt_reg - 1'b1;
            end else if (bits_reg == '0) begin
               busy <= 1'b0;
               done <= 1'b1;
               drive_low <= 1'b0;
            end else begin
               frame_reg <= {1'b1, frame_reg[9:1]};
               bits_reg <= bits_reg - 1'b1;
               cnt_reg <= 4'(BIT_TICKS - 1);
               drive_low <= ~frame_reg[1];
            end
         end
      end
   end
endmodule

module shm_device import shm_pkg::*; #(
   parameter int TIMEOUT_CYCLES = CMD_TIMEOUT_CYCLES, // missing data byte wait
   parameter int RESP_CYCLES = RESP_MAX_CYCLES // longest reply latency
) (
   input wire logic clk_sys, // system clock, 200 MHz
   input wire logic rst_n, // async reset, active low
   shm_if.dev link, // shared message line
   input wire logic chip_en, // chip enable, low forbids initiating
   input wire logic [7:0] status_in, // live status conditions
   input wire logic [7:0] reply_data, // data byte for read commands
   output logic cmd_valid, // queued command available
   output logic [4:0] cmd_code, // queued command code
   output logic [7:0] cmd_data, // queued command data
   input wire logic cmd_ready, // user takes command
   input wire logic mode_req, // standby or sleep wanted
   output logic mode_grant // mode change may proceed
);
   typedef enum {S_IDLE, S_WAIT_DATA, S_PUSH, S_SEND1, S_WAIT1, S_SEND2, S_WAIT2} shm_dev_state_t;
   shm_dev_state_t state_reg;
   logic line_meta_reg, line_sync_reg;
   logic [TICK_W-1:0] div_reg;
   logic tick_reg;
   logic [7:0] cmd_reg, byte1_reg, byte2_reg, stat_prev_reg, pend_reg;
   logic two_reg;
   logic [TIMER_W-1:0] timer_reg;
   logic rx_busy, rx_valid, rx_err, tx_busy, tx_done, tx_collide, tx_low;
   logic [7:0] rx_byte, tx_byte;
   logic fifo_ready, tx_start, line_free, unsol_take;
   logic [7:0] rise;
   logic [4:0] gap_reg;

   // two flops before anything looks at the line
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         line_meta_reg <= 1'b1;
         line_sync_reg <= 1'b1;
      end else begin
         line_meta_reg <= link.line;
         line_sync_reg <= line_meta_reg;
      end
   end

   // 16x oversampling tick
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         div_reg <= '0;
         tick_reg <= 1'b0;
      end else begin
         tick_reg <= div_reg == TICK_W'(TICK_DIV - 1);
         div_reg <= (div_reg == TICK_W'(TICK_DIV - 1)) ? '0 : div_reg + 1'b1;
      end
   end

   shm_rx u_rx (.clk_sys(clk_sys), .rst_n(rst_n), .tick(tick_reg), .line_sync(line_sync_reg),
      .enable(!tx_busy), .busy(rx_busy), .byte_valid(rx_valid), .byte_data(rx_byte), .frame_err(rx_err));

   shm_tx u_tx (.clk_sys(clk_sys), .rst_n(rst_n), .tick(tick_reg), .start(tx_start), .data(tx_byte),
      .line_sync(line_sync_reg), .busy(tx_busy), .done(tx_done), .drive_low(tx_low), .collide(tx_collide));

   shm_fifo #(.WIDTH(CMD_WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (.clk_sys(clk_sys), .rst_n(rst_n),
      .in_valid(state_reg == S_PUSH), .in_ready(fifo_ready), .in_data({cmd_reg[4:0], byte2_reg}),
      .out_valid(cmd_valid), .out_ready(cmd_ready), .out_data({cmd_code, cmd_data}));

   // open drain: enable only while pulling low
   assign link.dev_out = 1'b0;
   assign link.dev_oe = tx_low;

   assign line_free = !rx_busy && !tx_busy && line_sync_reg && (gap_reg == '0);

   // rx goes idle at the stop sample, half a bit before the sender lets go of the
   // line; wait one more bit time so a reply never lands on the host's own stop bit
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) gap_reg <= '0;
      else if (rx_busy) gap_reg <= 5'(BIT_TICKS);
      else if (tick_reg && gap_reg != '0) gap_reg <= gap_reg - 1'b1;
   end
   assign tx_start = ((state_reg == S_SEND1) || (state_reg == S_SEND2)) && line_free;
   assign tx_byte = (state_reg == S_SEND2) ? byte2_reg : byte1_reg;
   assign rise = status_in & ~stat_prev_reg;
   assign unsol_take = (state_reg == S_IDLE) && !rx_valid && chip_en && (pend_reg != '0) && line_free;

   // pending rising status bits; a new rise wins over the clear on send
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         stat_prev_reg <= '0;
         pend_reg <= '0;
      end else begin
         stat_prev_reg <= status_in;
         pend_reg <= (unsol_take ? 8'h00 : pend_reg) | rise;
      end
   end

   // command parsing and reply sequencing
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= S_IDLE;
         cmd_reg <= '0;
         byte1_reg <= '0;
         byte2_reg <= '0;
         two_reg <= 1'b0;
         timer_reg <= '0;
      end else begin
         case (state_reg)
            S_IDLE: begin
               timer_reg <= '0;
               if (rx_valid) begin
                  cmd_reg <= rx_byte;
                  byte2_reg <= '0;
                  if (!rx_byte[CMD_FLAG_BIT]) begin
                     state_reg <= S_IDLE;
                  end else if (!cmd_form_ok(rx_byte) || !code_in(CMDS_SUPPORTED, rx_byte[4:0])) begin
                     byte1_reg <= reply_byte(rx_byte, 1'b0);
                     two_reg <= 1'b0;
                     state_reg <= S_SEND1;
                  end else if (code_in(CMDS_TWO_BYTE, rx_byte[4:0])) begin
                     state_reg <= S_WAIT_DATA;
                  end else begin
                     state_reg <= S_PUSH;
                  end
               end else if (unsol_take) begin
                  byte1_reg <= reply_byte({3'h4, STATUS_CODE}, 1'b1);
                  byte2_reg <= status_in;
                  two_reg <= 1'b1;
                  state_reg <= S_SEND1;
               end
            end
            S_WAIT_DATA: begin
               timer_reg <= timer_reg + 1'b1;
               if (rx_valid) begin
                  byte2_reg <= rx_byte;
                  timer_reg <= '0;
                  state_reg <= S_PUSH;
               end else if (rx_err || timer_reg == TIMER_W'(TIMEOUT_CYCLES - 1)) begin
                  byte1_reg <= reply_byte(cmd_reg, 1'b0);
                  two_reg <= 1'b0;
                  state_reg <= S_SEND1;
               end
            end
            S_PUSH: begin
               timer_reg <= timer_reg + 1'b1;
               if (fifo_ready) begin
                  byte1_reg <= reply_byte(cmd_reg, 1'b1);
                  two_reg <= code_in(CMDS_READ, cmd_reg[4:0]);
                  byte2_reg <= reply_data;
                  state_reg <= S_SEND1;
               end else if (timer_reg == TIMER_W'(RESP_CYCLES - 1)) begin
                  byte1_reg <= reply_byte(cmd_reg, 1'b0);
                  two_reg <= 1'b0;
                  state_reg <= S_SEND1;
               end
            end
            S_SEND1: if (tx_start) state_reg <= S_WAIT1;
            S_WAIT1: begin
               if (tx_collide) state_reg <= S_IDLE;
               else if (tx_done) state_reg <= two_reg ? S_SEND2 : S_IDLE;
            end
            S_SEND2: if (tx_start) state_reg <= S_WAIT2;
            S_WAIT2: if (tx_done || tx_collide) state_reg <= S_IDLE;
            default: state_reg <= S_IDLE;
         endcase
      end
   end

   // hold off low-power entry while any message is in flight
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) mode_grant <= 1'b0;
      else mode_grant <= mode_req && !rx_busy && !tx_busy && (state_reg == S_IDLE) && !rx_valid;
   end
endmodule

//--- shm_host.sv
`timescale 1ns/10ps
// host end: sends bytes, receives bytes, backs off on contention
module shm_host import shm_pkg::*; (
   input wire logic clk_sys, // system clock, 200 MHz
   input wire logic rst_n, // async reset, active low
   shm_if.host link, // shared message line
   input wire logic peer_asleep, // device in sleep, do not talk
   input wire logic tx_valid, // byte to send
   input wire logic [7:0] tx_data, // byte value
   output logic tx_ready, // byte accepted when valid
   output logic rx_valid, // received byte pulse
   output logic [7:0] rx_data, // received byte
   output logic rx_err, // framing error pulse
   output logic collision // contention seen pulse
);
   logic line_meta_reg, line_sync_reg;
   logic [TICK_W-1:0] div_reg;
   logic tick_reg;
   logic [8:0] backoff_reg;
   logic rx_busy, tx_busy, tx_low, start;
   logic [4:0] gap_reg;

   // two flops before anything looks at the line
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         line_meta_reg <= 1'b1;
         line_sync_reg <= 1'b1;
      end else begin
         line_meta_reg <= link.line;
         line_sync_reg <= line_meta_reg;
      end
   end

   // 16x oversampling tick
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         div_reg <= '0;
         tick_reg <= 1'b0;
      end else begin
         tick_reg <= div_reg == TICK_W'(TICK_DIV - 1);
         div_reg <= (div_reg == TICK_W'(TICK_DIV - 1)) ? '0 : div_reg + 1'b1;
      end
   end

   shm_rx u_rx (.clk_sys(clk_sys), .rst_n(rst_n), .tick(tick_reg), .line_sync(line_sync_reg),
      .enable(!tx_busy), .busy(rx_busy), .byte_valid(rx_valid), .byte_data(rx_data), .frame_err(rx_err));

   shm_tx u_tx (.clk_sys(clk_sys), .rst_n(rst_n), .tick(tick_reg), .start(start), .data(tx_data),
      .line_sync(line_sync_reg), .busy(tx_busy), .done(), .drive_low(tx_low), .collide(collision));

   assign link.host_out = 1'b0;
   assign link.host_oe = tx_low;
   assign start = tx_valid && tx_ready;

   // a received frame is only over about half a bit after its stop sample; the sender's
   // receiver is still shut off until then, so hold our next start back
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) gap_reg <= '0;
      else if (rx_busy) gap_reg <= 5'(BIT_TICKS);
      else if (tick_reg && gap_reg != '0) gap_reg <= gap_reg - 1'b1;
   end

   // contention releases the line, then three packet times of silence
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) backoff_reg <= '0;
      else if (collision) backoff_reg <= 9'(BACKOFF_TICKS);
      else if (tick_reg && backoff_reg != '0) backoff_reg <= backoff_reg - 1'b1;
   end

   // ready drops in the accept cycle so one byte is never taken twice
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) tx_ready <= 1'b0;
      else tx_ready <= !start && !tx_busy && !rx_busy && line_sync_reg && !collision &&
         (backoff_reg == '0) && (gap_reg == '0) && !peer_asleep;
   end
endmodule

//--- shm_assertions.sv
`timescale 1ns/10ps
module shm_assertions import shm_pkg::*; (
   input wire logic clk_sys, // system clock
   input wire logic rst_n, // async reset, active low
   input wire logic dev_oe, // device pulls line
   input wire logic dev_out, // device drive level
   input wire logic host_oe, // host pulls line
   input wire logic host_out, // host drive level
   input wire logic line // resolved line level
);
   localparam logic [19:0] START_END = 20'(15 * TICK_DIV);
   localparam logic [19:0] STOP_BEG = 20'(146 * TICK_DIV);
   localparam logic [19:0] FRM_END = 20'(159 * TICK_DIV);
   localparam logic [19:0] RUN_MAX = 20'(147 * TICK_DIV);
   logic [19:0] dev_frm;
   logic [19:0] host_frm;
   logic [19:0] dev_run;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // cycles since each end began a frame; windows leave one to three ticks of slack for jitter
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         dev_frm <= 20'h0;
         host_frm <= 20'h0;
      end else begin
         dev_frm <= (dev_frm == 20'h0) ? {19'h0, dev_oe} : (dev_frm >= FRM_END) ? 20'h0 : dev_frm + 20'h1;
         host_frm <= (host_frm == 20'h0) ? {19'h0, host_oe} : (host_frm >= FRM_END) ? 20'h0 : host_frm + 20'h1;
      end
   end
   // length of the present pull by the device
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         dev_run <= 20'h0;
      end else begin
         dev_run <= dev_oe ? dev_run + 20'h1 : 20'h0;
      end
   end
   a_dev_open_drain: assert property (dev_oe |-> !dev_out && !line)
      else $error("device pull does not bring the line low");
   a_host_open_drain: assert property (host_oe |-> !host_out)
      else $error("host drives the line high");
   a_dev_start_low: assert property (dev_frm != 20'h0 && dev_frm < START_END |-> dev_oe)
      else $error("device start bit too short");
   a_dev_stop_high: assert property (dev_frm >= STOP_BEG |-> !dev_oe)
      else $error("device stop bit not released");
   a_host_start_low: assert property (host_frm != 20'h0 && host_frm < START_END |-> host_oe)
      else $error("host start bit too short");
   a_host_stop_high: assert property (host_frm >= STOP_BEG |-> !host_oe)
      else $error("host stop bit not released");
   a_dev_pull_len: assert property (dev_oe |-> dev_run < RUN_MAX)
      else $error("device pulls longer than nine bits");
   a_dev_waits_host: assert property ($rose(dev_oe) && dev_frm == 20'h0 |-> host_frm == 20'h0 || host_frm >= STOP_BEG)
      else $error("device started inside a host frame");
endmodule

//--- single_wire_host_message_port_bench.sv
`timescale 1ns/10ps
module single_wire_host_message_port_bench import shm_pkg::*;;
   localparam int TO_CYC = 400000;
   localparam int LAT = 161 * TICK_DIV + RESP_MAX_CYCLES;
   localparam int SEND_LIM = 700 * TICK_DIV;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic chip_en = 1'b0;
   logic mode_req = 1'b1;
   logic cmd_ready = 1'b0;
   logic tx_valid = 1'b0;
   logic [7:0] status_in = 8'h00;
   logic [7:0] reply_data = 8'hC3;
   logic [7:0] tx_data = 8'h00;
   logic cmd_valid, tx_ready, rx_valid, rx_err, collision, mode_grant;
   logic [4:0] cmd_code;
   logic [7:0] cmd_data, rx_data;
   logic [7:0] rxq[$];
   int n_fail = 0;
   int n_tests = 0;
   shm_if link();
   always #2.5 clk_sys = ~clk_sys;
   shm_device #(.TIMEOUT_CYCLES(TO_CYC)) i_shm_device (.clk_sys(clk_sys), .rst_n(rst_n), .link(link),
      .chip_en(chip_en), .status_in(status_in), .reply_data(reply_data), .cmd_valid(cmd_valid),
      .cmd_code(cmd_code), .cmd_data(cmd_data), .cmd_ready(cmd_ready), .mode_req(mode_req),
      .mode_grant(mode_grant));
   shm_host i_shm_host (.clk_sys(clk_sys), .rst_n(rst_n), .link(link), .peer_asleep(1'b0),
      .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid),
      .rx_data(rx_data), .rx_err(rx_err), .collision(collision));
   shm_assertions i_shm_assertions (.clk_sys(clk_sys), .rst_n(rst_n), .dev_oe(link.dev_oe),
      .dev_out(link.dev_out), .host_oe(link.host_oe), .host_out(link.host_out), .line(link.line));
   // host receptions are queued so a pulse is never missed between checks
   always @(posedge clk_sys) begin
      if (rx_valid === 1'b1) rxq.push_back(rx_data);
      if (rx_err | collision) check({rx_err, collision}, 16'h0);
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // an expired wait counts as a mismatch and ends the run
   task automatic give_up();
      check(16'h0, 16'h1);
      report_and_stop();
   endtask
   // host byte: valid held until the edge that sees ready
   task automatic send(input logic [7:0] b);
      int i;
      @(posedge clk_sys);
      tx_valid <= 1'b1;
      tx_data <= b;
      for (i = 0; i < SEND_LIM; i++) begin
         @(posedge clk_sys);
         if (tx_ready === 1'b1) break;
      end
      tx_valid <= 1'b0;
      if (i >= SEND_LIM) give_up();
   endtask
   // device byte: sample the wire at each bit centre, then the host's copy
   task automatic expect_byte(input logic [7:0] exp, input int lim, output int waited);
      int i;
      logic [9:0] w;
      for (i = 0; i < lim && link.dev_oe !== 1'b1; i++) @(posedge clk_sys);
      waited = i;
      if (i >= lim) give_up();
      for (i = 0; i < 10; i++) begin
         repeat (i == 0 ? 8 * TICK_DIV : 16 * TICK_DIV) @(posedge clk_sys);
         w[i] = link.line;
      end
      check(mode_grant, 1'b0);
      check(w, {1'b1, exp, 1'b0});
      for (i = 0; i < 4 * TICK_DIV && rxq.size() == 0; i++) @(posedge clk_sys);
      if (rxq.size() == 0) rxq.push_back(~exp);
      check(rxq.pop_front(), exp);
   endtask
   // no device pull for n cycles
   task automatic quiet(input int n);
      logic seen;
      seen = 1'b0;
      repeat (n) begin
         @(posedge clk_sys);
         if (link.dev_oe !== 1'b0) seen = 1'b1;
      end
      check(seen, 1'b0);
   endtask
   task automatic pop_cmd(input logic [4:0] c, input logic [7:0] d);
      int i;
      for (i = 0; i < 1000 && cmd_valid !== 1'b1; i++) @(posedge clk_sys);
      check(cmd_valid, 1'b1);
      check({cmd_code, cmd_data}, {c, d});
      cmd_ready <= 1'b1;
      @(posedge clk_sys);
      cmd_ready <= 1'b0;
   endtask
   initial begin
      logic [7:0] tab[5];
      logic [7:0] c;
      logic ok;
      int w;
      tab = '{8'h81, 8'hA1, 8'hC3, 8'h9F, 8'h87};
      repeat (10) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      // one-byte commands: reads, reserved bits set, unsupported code
      foreach (tab[k]) begin
         c = tab[k];
         ok = (c[6:5] == 2'h0) && CMDS_SUPPORTED[c[4:0]];
         send(c);
         expect_byte({1'b0, ok, c[5:0]}, LAT, w);
         if (ok) begin
            expect_byte(reply_data, LAT, w);
            pop_cmd(c[4:0], 8'h00);
         end
      end
      // two-byte command sent back to back
      send(8'h80);
      send(8'h5A);
      expect_byte(8'h40, LAT, w);
      pop_cmd(5'h00, 8'h5A);
      // two-byte command whose data never comes
      send(8'h84);
      expect_byte(8'h04, LAT + TO_CYC, w);
      check(w >= TO_CYC, 1'b1);
      // status rise held back while enable is low, sent once it is high
      status_in <= 8'h01;
      quiet(40000);
      chip_en <= 1'b1;
      expect_byte({3'h2, STATUS_CODE}, 1000, w);
      expect_byte(8'h01, LAT, w);
      status_in <= 8'h00;
      quiet(40000);
      check(mode_grant, 1'b1);
      report_and_stop();
   end
endmodule
